// *** design/adc_consts.svh ***
// Behaviour
// RULE1: a Stop after a successful address, read or write, starts a conversion.
// RULE2: while converting, the address is never acknowledged; afterwards requests are accepted again.
// RULE3: a read shifts out the latest completed result at once, no pipeline delay.
// RULE4: a read sends twelve result bits, then four zero bits, sixteen bits total.
// RULE5: output data changes on serial clock falling edges, master samples on rising.
// RULE6: write data bits are sampled on serial clock rising edges.
// RULE7: after a read the master uses Repeated Start to write, or Stop to convert.
// RULE8: a write loads a six-bit configuration word: input selection and operating modes.
// RULE9: configuration arrives most significant first, select bit first, sleep bit sixth.
// RULE10: differential mode: channel selects pick the pair, odd/sign picks which is positive.
// RULE11: single-ended mode: positive input is 2*select+odd/sign, negative is the common input.
// RULE12: every conversion may use a new selection, independent of the previous one.
// RULE13: one configuration bit picks unipolar or bipolar range, which sets result coding.
// RULE14: one configuration bit requests sleep while the converter is inactive.
// RULE15: the device is only a slave and never drives the serial clock.
// RULE16: data line released while receiving, driven only open-drain low while transmitting.
// RULE17: each address pin is decoded as low, high or floating into the address.
// RULE18: approximation resolves result bits from most to least significant.
// RULE19: at conversion end the twelve-bit result moves into output latches.
// RULE20: conversion is internally timed and finishes within 1.8 microseconds.
// RULE21: when addressed, a write takes configuration, a read returns the last result.
// RULE22: new configuration applies at the next Stop; output is two acknowledged bytes. The sleep bit drives sleep_request as soon as it is received.
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// configuration word field positions, first received bit is bit 5
`define CFG_SINGLE_ENDED_BIT 5
`define CFG_ODD_SIGN_BIT 4
`define CFG_CHANNEL_HI_BIT 3
`define CFG_CHANNEL_LO_BIT 2
`define CFG_POLARITY_BIT 1
`define CFG_SLEEP_BIT 0
`define CFG_RESET 6'h00
`define RESULT_RESET 12'h000
`define SAR_FIRST_TRIAL 12'h800

// bit counts on the serial bus
`define BITS_PER_BYTE 4'h8
`define LAST_BIT_OF_BYTE 4'h7
`define CFG_LAST_BIT 4'h5
`define TAIL_ZEROS 4'h0

// conversion timing
`define CLK_PERIOD_NS 100
`define CONV_MAX_NS 1800
`define CONV_MAX_CYCLES (`CONV_MAX_NS / `CLK_PERIOD_NS)

`endif

// *** design/adc_types_pkg.sv ***
package adc_types_pkg;
    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_AACK, B_RD, B_MACK, B_WR, B_WACK, B_SKIP
    } bus_state_e;
    typedef enum logic [1:0] {C_IDLE, C_SAMPLE, C_BITS} conv_state_e;
    typedef logic [5:0] config_t;
    typedef logic [11:0] code_t;
endpackage : adc_types_pkg

// *** design/i2c_adc_conversion_control.sv ***
`timescale 1ns/10ps
`include "adc_consts.svh"
module i2c_adc_conversion_control import adc_types_pkg::*; #(
    parameter logic [6:0] ADDR_BASE = 7'h10, // arbitrary base address
    parameter int STEP_DIV = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] address_pin_a,
    input wire logic [1:0] address_pin_b,
    input wire logic comp_in,
    output code_t dac_code,
    output logic sample_hold,
    output logic [2:0] mux_pos,
    output logic [2:0] mux_neg,
    output logic mux_neg_common,
    output logic polarity_select,
    output logic sleep_request,
    output logic busy
);
    localparam int CONV_HI = `CONV_MAX_CYCLES * STEP_DIV; // slower conversion clock scales it

    logic rst_meta;
    logic rst_sync_b;
    logic [6:0] own_addr;
    logic [6:0] next_own_addr;
    logic strap_done;
    logic [1:0] pin_a_digit;
    logic [1:0] pin_b_digit;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    bus_state_e bus_state, next_bus_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx, next_rx;
    logic [15:0] tx, next_tx;
    logic next_sda_oe;
    logic addressed, next_addressed;
    logic read_dir, next_read_dir;
    logic second_byte, next_second_byte;
    logic master_nack, next_master_nack;
    config_t cfg, next_cfg;
    logic conv_req, next_conv_req;
    conv_state_e conv_state, next_conv_state;
    code_t next_dac_code;
    code_t result, next_result;
    logic [3:0] bit_idx, next_bit_idx;
    logic [7:0] div_cnt, next_div_cnt;
    logic next_sample_hold;
    logic [2:0] next_mux_pos;
    logic [2:0] next_mux_neg;
    logic next_mux_neg_common;
    logic next_polarity_select;
    logic next_sleep_request;
    logic next_busy;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // three-state pin decode: low 0, high 1, float 2
    always_comb begin
        pin_a_digit = address_pin_a[1] ? 2'h2 : {1'b0, address_pin_a[0]}; // RULE17
        pin_b_digit = address_pin_b[1] ? 2'h2 : {1'b0, address_pin_b[0]}; // RULE17
        next_own_addr = ADDR_BASE + 7'(3 * pin_a_digit) + 7'(pin_b_digit); // RULE17
    end

    // straps caught once after reset release
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            own_addr <= 7'h00;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            own_addr <= next_own_addr;
            strap_done <= 1'b1;
        end
    end

    // bus line history and condition detect, scl is input only
    always_comb begin
        scl_rise = scl_in & ~scl_q; // RULE15
        scl_fall = ~scl_in & scl_q;
        start_seen = scl_in & scl_q & sda_q & ~sda_in;
        stop_seen = scl_in & scl_q & ~sda_q & sda_in;
    end

    // serial slave next state
    always_comb begin
        next_bus_state = bus_state;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_sda_oe = sda_oe;
        next_addressed = addressed;
        next_read_dir = read_dir;
        next_second_byte = second_byte;
        next_master_nack = master_nack;
        next_cfg = cfg;
        next_conv_req = 1'b0;
        if (!strap_done) begin
            next_bus_state = B_IDLE;
        end else if (stop_seen) begin
            next_bus_state = B_IDLE;
            next_sda_oe = 1'b0;
            next_conv_req = addressed; // RULE1 RULE22
            next_addressed = 1'b0;
        end else if (start_seen) begin
            next_bus_state = B_ADDR; // RULE7
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
        end else begin
            case (bus_state)
                B_ADDR: begin
                    if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
                        next_rx = {rx[6:0], sda_in}; // RULE6
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                        if (rx[7:1] == own_addr && !busy) begin // RULE2
                            next_sda_oe = 1'b1;
                            next_addressed = 1'b1;
                            next_read_dir = rx[0];
                            next_bus_state = B_AACK;
                        end else begin
                            next_bus_state = B_SKIP; // RULE2
                        end
                    end
                end
                B_AACK: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (read_dir) begin
                            next_tx = {result, `TAIL_ZEROS}; // RULE3 RULE4 RULE21
                            next_sda_oe = ~result[11]; // RULE5 RULE16
                            next_second_byte = 1'b0;
                            next_bus_state = B_RD;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_bus_state = B_WR;
                        end
                    end
                end
                B_RD: begin
                    if (scl_fall) begin
                        if (bit_cnt == `LAST_BIT_OF_BYTE) begin
                            next_sda_oe = 1'b0;
                            next_bus_state = B_MACK; // RULE22
                        end else begin
                            next_sda_oe = ~tx[14]; // RULE5 RULE16
                            next_tx = {tx[14:0], 1'b0};
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                B_MACK: begin
                    if (scl_rise) begin
                        next_master_nack = sda_in;
                    end else if (scl_fall) begin
                        if (!master_nack && !second_byte) begin
                            next_sda_oe = ~tx[14]; // RULE5 RULE22
                            next_tx = {tx[14:0], 1'b0};
                            next_bit_cnt = 4'h0;
                            next_second_byte = 1'b1;
                            next_bus_state = B_RD;
                        end else begin
                            next_bus_state = B_SKIP;
                        end
                    end
                end
                B_WR: begin
                    if (scl_rise && bit_cnt != `BITS_PER_BYTE) begin
                        next_rx = {rx[6:0], sda_in}; // RULE6
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == `CFG_LAST_BIT) begin
                            next_cfg = {rx[4:0], sda_in}; // RULE8 RULE9 RULE21
                        end
                    end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                        next_sda_oe = 1'b1;
                        next_bus_state = B_WACK;
                    end
                end
                B_WACK: begin
                    if (scl_fall) begin
                        next_sda_oe = 1'b0; // RULE16
                        next_bit_cnt = 4'h0;
                        next_bus_state = B_WR;
                    end
                end
                default: begin
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // serial slave registers
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bus_state <= B_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 16'h0000;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            addressed <= 1'b0;
            read_dir <= 1'b0;
            second_byte <= 1'b0;
            master_nack <= 1'b0;
            cfg <= `CFG_RESET;
            conv_req <= 1'b0;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            bus_state <= next_bus_state;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            sda_oe <= next_sda_oe;
            sda_out <= 1'b0;
            addressed <= next_addressed;
            read_dir <= next_read_dir;
            second_byte <= next_second_byte;
            master_nack <= next_master_nack;
            cfg <= next_cfg;
            conv_req <= next_conv_req;
        end
    end

    // conversion sequencer next state
    always_comb begin
        next_conv_state = conv_state;
        next_dac_code = dac_code;
        next_result = result;
        next_bit_idx = bit_idx;
        next_div_cnt = div_cnt;
        next_sample_hold = 1'b0;
        next_mux_pos = mux_pos;
        next_mux_neg = mux_neg;
        next_mux_neg_common = mux_neg_common;
        next_polarity_select = polarity_select;
        next_busy = busy;
        case (conv_state)
            C_IDLE: begin
                if (conv_req) begin
                    next_mux_pos = {cfg[`CFG_CHANNEL_HI_BIT], cfg[`CFG_CHANNEL_LO_BIT],
                                    cfg[`CFG_ODD_SIGN_BIT]}; // RULE10 RULE11 RULE12
                    next_mux_neg = {cfg[`CFG_CHANNEL_HI_BIT], cfg[`CFG_CHANNEL_LO_BIT],
                                    ~cfg[`CFG_ODD_SIGN_BIT]}; // RULE10
                    next_mux_neg_common = cfg[`CFG_SINGLE_ENDED_BIT]; // RULE11
                    next_polarity_select = cfg[`CFG_POLARITY_BIT]; // RULE13
                    next_sample_hold = 1'b1;
                    next_busy = 1'b1;
                    next_conv_state = C_SAMPLE;
                end
            end
            C_SAMPLE: begin
                next_dac_code = `SAR_FIRST_TRIAL; // RULE18
                next_bit_idx = 4'hB;
                next_div_cnt = 8'h00;
                next_conv_state = C_BITS;
            end
            C_BITS: begin
                if (div_cnt == 8'(STEP_DIV - 1)) begin
                    next_div_cnt = 8'h00;
                    if (!comp_in) begin
                        next_dac_code[bit_idx] = 1'b0;
                    end
                    if (bit_idx == 4'h0) begin
                        // offset binary to two's complement in bipolar range
                        next_result = polarity_select ? next_dac_code :
                            {~next_dac_code[11], next_dac_code[10:0]}; // RULE13 RULE19
                        next_busy = 1'b0; // RULE20
                        next_conv_state = C_IDLE;
                    end else begin
                        next_dac_code[bit_idx - 4'h1] = 1'b1; // RULE18
                        next_bit_idx = bit_idx - 4'h1;
                    end
                end else begin
                    next_div_cnt = div_cnt + 8'h01;
                end
            end
            default: begin
                next_conv_state = C_IDLE;
                next_busy = 1'b0;
            end
        endcase
        next_sleep_request = !next_busy && cfg[`CFG_SLEEP_BIT]; // RULE14
    end

    // conversion sequencer registers
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            conv_state <= C_IDLE;
            dac_code <= 12'h000;
            result <= `RESULT_RESET;
            bit_idx <= 4'h0;
            div_cnt <= 8'h00;
            sample_hold <= 1'b0;
            mux_pos <= 3'h0;
            mux_neg <= 3'h1;
            mux_neg_common <= 1'b0;
            polarity_select <= 1'b0;
            sleep_request <= 1'b0;
            busy <= 1'b0;
        end else begin
            conv_state <= next_conv_state;
            dac_code <= next_dac_code;
            result <= next_result;
            bit_idx <= next_bit_idx;
            div_cnt <= next_div_cnt;
            sample_hold <= next_sample_hold;
            mux_pos <= next_mux_pos;
            mux_neg <= next_mux_neg;
            mux_neg_common <= next_mux_neg_common;
            polarity_select <= next_polarity_select;
            sleep_request <= next_sleep_request;
            busy <= next_busy;
        end
    end

    // checks on the design's own outputs
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_b);

    busy_addr_nak_a: assert property ( // RULE2
        bus_state == B_ADDR && scl_fall && bit_cnt == `BITS_PER_BYTE && busy
        |=> !sda_oe && bus_state == B_SKIP) else $error("address acknowledged while busy");
    stop_starts_conv_a: assert property ( // RULE1
        stop_seen && addressed && strap_done |=> conv_req ##1 busy)
        else $error("stop after address did not start conversion");
    tail_zero_a: assert property ( // RULE4
        bus_state == B_RD && second_byte && bit_cnt >= 4'h4 |-> sda_oe && !sda_out)
        else $error("trailing bit not zero");
    oe_on_fall_a: assert property ( // RULE5
        $changed(sda_oe) |-> $past(scl_fall || stop_seen || start_seen))
        else $error("data line changed away from falling edge");
    conv_time_a: assert property ( // RULE20
        $rose(busy) |-> ##[1:CONV_HI] !busy) else $error("conversion too long");
    msb_first_a: assert property ( // RULE18
        conv_state == C_SAMPLE |=> dac_code == `SAR_FIRST_TRIAL && bit_idx == 4'hB)
        else $error("approximation not starting at top bit");
    result_hold_a: assert property ( // RULE19
        busy && $past(busy) |-> $stable(result)) else $error("result changed mid conversion");
    cfg_load_a: assert property ( // RULE9
        bus_state == B_WR && scl_rise && bit_cnt == `CFG_LAST_BIT && !stop_seen && !start_seen
        |=> cfg == {$past(rx[4:0]), $past(sda_in)}) else $error("config word misloaded");
    mux_apply_a: assert property ( // RULE11
        $rose(busy) |-> mux_pos == {$past(cfg[3:2]), $past(cfg[4])}
        && mux_neg_common == $past(cfg[5])) else $error("mux selection wrong");
    sleep_busy_a: assert property ( // RULE14
        busy |-> !sleep_request) else $error("sleep while converting");
    write_release_a: assert property ( // RULE16
        bus_state == B_WR |-> !sda_oe && !sda_out) else $error("data line driven on write");

    read_cover_c: cover property (bus_state == B_MACK && second_byte && scl_fall);
    write_cover_c: cover property (bus_state == B_WACK && scl_fall);
    conv_cover_c: cover property ($fell(busy));
    nak_cover_c: cover property (bus_state == B_ADDR ##1 bus_state == B_SKIP && busy);

endmodule : i2c_adc_conversion_control

// *** dv/i2c_master_model.sv ***
`timescale 1ns/10ps
module i2c_master_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // master owns the clock and only ever pulls data low
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // wait n falling edges of the system clock
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask : hold

    // start from idle, or repeated start when the clock is low
    task automatic start_cond();
        if (scl === 1'b0) begin
            sda_pull = 1'b0;
            hold(2);
            scl = 1'b1;
            hold(4);
        end
        sda_pull = 1'b1;
        hold(4);
        scl = 1'b0;
        hold(1);
    endtask : start_cond

    // stop from a low clock phase
    task automatic stop_cond();
        sda_pull = 1'b1;
        hold(4);
        scl = 1'b1;
        hold(4);
        sda_pull = 1'b0;
        hold(6);
    endtask : stop_cond

    // one bit: set data while low, capture while high
    task automatic bit_xfer(input logic b, output logic r);
        sda_pull = ~b;
        hold(3);
        scl = 1'b1;
        hold(2);
        r = sda_line;
        hold(2);
        scl = 1'b0;
        hold(1);
    endtask : bit_xfer

    // byte out, msb first, ack true when the device pulled low
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask : send_byte

    // byte in, then master ack (1) or nack (0)
    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(~ack, r);
    endtask : recv_byte
endmodule : i2c_master_model

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench import adc_types_pkg::*;;
    localparam int STEP = 8;
    localparam logic [6:0] BASE = 7'h10;
    localparam logic [6:0] DEV_ADDR = BASE + 7'h07; // float digit 2, high digit 1
    logic clk, rst_b, comp_in, scl, m_pull, sda_out, sda_oe, sample_hold;
    logic mux_neg_common, polarity_select, sleep_request, busy, ack;
    logic [2:0] mux_pos, mux_neg;
    logic [7:0] b1, b2;
    logic [5:0] cfg;
    logic [1:0] pin_a, pin_b;
    logic [11:0] vin, exp_code;
    logic [11:0] ana [8];
    logic [15:0] rnd;
    code_t dac_code;
    int bad_count, total_checks, busy_run, last_len;
    wire sda_line;

    // open-drain data wire with pull-up
    assign sda_line = ~(m_pull | (sda_oe & ~sda_out));

    i2c_adc_conversion_control #(.ADDR_BASE(BASE), .STEP_DIV(STEP)) u_i2c_adc_conversion_control (
        .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .address_pin_a(pin_a), .address_pin_b(pin_b),
        .comp_in(comp_in), .dac_code(dac_code), .sample_hold(sample_hold),
        .mux_pos(mux_pos), .mux_neg(mux_neg), .mux_neg_common(mux_neg_common),
        .polarity_select(polarity_select), .sleep_request(sleep_request), .busy(busy)
    );

    i2c_master_model u_master (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(m_pull)
    );

    // clock generator
    always #50 clk = ~clk;

    // analog front end: hold selected input, compare with trial word
    always @(negedge clk) begin
        if (sample_hold === 1'b1) begin
            vin = ana[mux_pos];
        end
        comp_in <= (vin >= dac_code);
    end

    // length of the last busy period
    always @(posedge clk) begin
        if (busy === 1'b1) begin
            busy_run++;
        end else if (busy_run != 0) begin
            last_len = busy_run;
            busy_run = 0;
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr_next

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // bounded wait for a busy level
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            bad_count++;
            print_verdict();
        end
    endtask : wait_busy

    task automatic new_analog();
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            ana[i] = rnd[11:0];
        end
    endtask : new_analog

    // addressed read of both bytes, compared with the model
    task automatic read_check();
        u_master.start_cond();
        u_master.send_byte({DEV_ADDR, 1'b1}, ack);
        check(16'(ack), 16'h0001);
        u_master.recv_byte(1'b1, b1);
        u_master.recv_byte(1'b0, b2);
        check({b1, b2}, {exp_code, 4'h0});
    endtask : read_check

    // main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        pin_a = 2'b10;
        pin_b = 2'b01;
        comp_in = 1'b0;
        vin = 12'h000;
        rnd = 16'h0014;
        bad_count = 0;
        total_checks = 0;
        busy_run = 0;
        last_len = 0;
        new_analog();
        repeat (20) @(negedge clk);
        check(16'(sda_oe), 16'h0000);
        rst_b = 1'b1;
        repeat (10) @(negedge clk);
        // wrong address is ignored
        u_master.start_cond();
        u_master.send_byte({BASE, 1'b1}, ack);
        check(16'(ack), 16'h0000);
        u_master.stop_cond();
        check(16'(busy), 16'h0000);
        for (int k = 0; k < 16; k++) begin
            cfg = {k[3:0], k[1] ^ k[2], rnd[0]};
            new_analog();
            exp_code = ana[{cfg[3:2], cfg[4]}] ^ (cfg[1] ? 12'h000 : 12'h800);
            u_master.start_cond();
            u_master.send_byte({DEV_ADDR, 1'b0}, ack);
            check(16'(ack), 16'h0001);
            u_master.send_byte({cfg, rnd[2:1]}, ack);
            check(16'(ack), 16'h0001);
            u_master.stop_cond();
            wait_busy(1'b1);
            check(16'(mux_pos), 16'({cfg[3:2], cfg[4]}));
            check(16'(mux_neg_common), 16'(cfg[5]));
            if (cfg[5] == 1'b0) begin
                check(16'(mux_neg), 16'({cfg[3:2], ~cfg[4]}));
            end
            check(16'(polarity_select), 16'(cfg[1]));
            // address attempt while converting
            u_master.start_cond();
            u_master.send_byte({DEV_ADDR, 1'b1}, ack);
            check(16'(ack), 16'h0000);
            u_master.stop_cond();
            wait_busy(1'b0);
            // let the busy length monitor close its count
            @(negedge clk);
            check(16'(dac_code), 16'(ana[{cfg[3:2], cfg[4]}]));
            check(16'(last_len), 16'(1 + 12 * STEP));
            check(16'(sleep_request), 16'(cfg[0]));
            read_check();
            read_check();
            u_master.stop_cond();
            check(16'(busy), 16'h0001);
            wait_busy(1'b0);
        end
        // second reset with other straps: low digit 0, float digit 2
        rst_b = 1'b0;
        pin_a = 2'b00;
        pin_b = 2'b10;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        repeat (10) @(negedge clk);
        u_master.start_cond();
        u_master.send_byte({DEV_ADDR, 1'b0}, ack);
        check(16'(ack), 16'h0000);
        u_master.stop_cond();
        check(16'(busy), 16'h0000);
        u_master.start_cond();
        u_master.send_byte({BASE + 7'h02, 1'b0}, ack);
        check(16'(ack), 16'h0001);
        u_master.stop_cond();
        check(16'(busy), 16'h0001);
        wait_busy(1'b0);
        check(16'(sleep_request), 16'h0000);
        print_verdict();
    end
endmodule : testbench
